// ---- src/tone_meter_pkg.sv ----
// Constants for the receive tone frequency meter and no-tone timer.
// Assumes a crystal-rate square wave arriving on a pin, sampled by core_clk.
//
// Functional notes
// - Measure filtered tone over a fixed window.
// - Count whole cycles, then measuring-clock remainder.
// - Successful window sets done flag and interrupt.
// - Result: byte 1 integer, byte 0 remainder.
// - High and mid band count doubled cycles.
// - Window 9.125 ms high/extended, 18.250 ms mid.
// - Measuring clock 56 kHz, or 28 kHz mid.
// - High band: floor count, rounded 56 kHz remainder.
// - Mid band: floor count, rounded 28 kHz remainder.
// - Extended band counts single cycles at 56 kHz.
// - All timing scales with the crystal frequency.
// - Command 0x33 plus one byte sets timer.
// - Code k gives k*20 ms or k*40 ms.
// - Timer setting writable in every mode.
// - One-shot, restarted only by successful measurement.
// - No countdown before a valid measurement.
// - Countdown from last success or signal loss.
// - Expiry sets no-tone flag and interrupt.
// - Flag cleared by status read, write, reset.
// - General reset loads setting zero.
// - Measurement complete is status bit 0.
// - No-tone expiry is status bit 1.
// - Expiry deferred when measurement over 75% done.
package tone_meter_pkg;
  // ==========================================================================
  // Timing, in crystal periods and measuring-clock ticks.
  localparam int MEAS_HI_HZ     = 56000;
  localparam int WINDOW_HI_US   = 9125;
  localparam int NT_UNIT_HI_MS  = 20;
  localparam logic [7:0] XTAL_PER_TICK_HI  = 8'h48;
  localparam logic [7:0] XTAL_PER_TICK_MID = 8'h90;
  localparam logic [8:0] WIN_TICKS =
    9'(WINDOW_HI_US * MEAS_HI_HZ / 1000000);
  localparam logic [8:0] LATE_TICKS = 9'(WINDOW_HI_US * MEAS_HI_HZ * 3 / 4000000);
  localparam logic [14:0] NT_UNIT_TICKS = 15'(NT_UNIT_HI_MS * MEAS_HI_HZ / 1000);
  // ==========================================================================
  // Serial commands and band codes.
  localparam logic [7:0] CMD_GEN_RESET = 8'h01;
  localparam logic [7:0] CMD_FREQ_READ = 8'h32;
  localparam logic [7:0] CMD_NT_WRITE  = 8'h33;
  localparam logic [7:0] CMD_STAT_READ = 8'h39;
  localparam logic [1:0] BAND_HIGH = 2'h0;
  localparam logic [1:0] BAND_MID  = 2'h1;
  localparam logic [1:0] BAND_EXT  = 2'h2;
  localparam int STAT_MEAS_BIT = 0;
  localparam int STAT_NT_BIT   = 1;
  typedef enum logic [1:0] {BUS_ADDR = 2'b00, BUS_WDATA = 2'b01,
                            BUS_RDATA = 2'b10, BUS_SKIP = 2'b11} bus_state_e;
  typedef enum logic {MEAS_IDLE = 1'b0, MEAS_RUN = 1'b1} meas_state_e;
endpackage

// ---- src/rx_tone_meter.sv ----
// Receive tone frequency meter, no-tone timer and serial command slave.
// Assumes xtal_pin, tone_pin and the serial pins are asynchronous to
// core_clk; band and enable inputs come from logic on core_clk.
`timescale 1ns/100ps
module rx_tone_meter #(
  // Ticks per no-tone code step; the default is the nominal 20 ms step.
  parameter logic [14:0] NT_UNIT = tone_meter_pkg::NT_UNIT_TICKS
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       xtal_pin,
  input  wire logic       tone_pin,
  input  wire logic       tone_ok,
  input  wire logic [1:0] band_sel,
  input  wire logic       irq_en_meas,
  input  wire logic       irq_en_notone,
  input  wire logic       bus_clk,
  input  wire logic       bus_cmd,
  input  wire logic       bus_csn,
  output logic            bus_reply,
  output logic            irq_n
);
  // ==========================================================================
  // State record.
  typedef struct packed {
    logic [2:0]  xs;
    logic [2:0]  ts;
    logic [2:0]  bc;
    logic [1:0]  bd;
    logic [1:0]  bs;
    logic [7:0]  pre;
    tone_meter_pkg::meas_state_e mstate;
    logic [8:0]  tcnt;
    logic [7:0]  ncnt;
    logic [8:0]  edge_tick;
    logic [7:0]  res_n;
    logic [7:0]  res_r;
    logic        meas_flag;
    logic        nt_flag;
    logic [3:0]  setting;
    logic        armed;
    logic        pending;
    logic [14:0] nt_cnt;
    tone_meter_pkg::bus_state_e bstate;
    logic [7:0]  shreg;
    logic [2:0]  bitcnt;
    logic [15:0] txreg;
    logic        reply;
    logic        irq_n;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic   xtal_edge;
  logic   tick;
  logic   tone_edge;
  logic   success;
  logic   abort;
  logic   expire;
  logic   late;
  logic   byte_done;
  logic   wr_setting;
  logic   gen_reset;
  logic   stat_read;
  logic [7:0]  rx_byte;
  logic [7:0]  divisor;
  logic [8:0]  rem;

  // Rounds an edge time to the nearest tick using the phase in the tick.
  function automatic logic [8:0] round_tick(input logic [8:0] t,
                                            input logic [7:0] ph,
                                            input logic [7:0] div);
    round_tick = (ph >= (div >> 1)) ? t + 9'h001 : t;
  endfunction

  // ==========================================================================
  // Next-state logic.
  always_comb
  begin
    st_next = st_reg;
    // Synchronisers; the second stage feeds the logic, and the third stage only the edge detectors.
    st_next.xs = {st_reg.xs[1:0], xtal_pin};
    st_next.ts = {st_reg.ts[1:0], tone_pin};
    st_next.bc = {st_reg.bc[1:0], bus_clk};
    st_next.bd = {st_reg.bd[0], bus_cmd};
    st_next.bs = {st_reg.bs[0], bus_csn};
    xtal_edge = st_reg.xs[1] & ~st_reg.xs[2];
    // Mid band ticks at half rate, so both windows last 511 ticks.
    divisor = (band_sel == tone_meter_pkg::BAND_MID) ?
              tone_meter_pkg::XTAL_PER_TICK_MID : tone_meter_pkg::XTAL_PER_TICK_HI;
    tick = xtal_edge && (st_reg.pre == divisor - 8'h01);
    if (xtal_edge)
    begin
      st_next.pre = tick ? 8'h00 : st_reg.pre + 8'h01;
    end
    // Extended band counts single cycles; the others count both edges.
    if (band_sel == tone_meter_pkg::BAND_EXT)
    begin
      tone_edge = st_reg.ts[1] & ~st_reg.ts[2];
    end
    else
    begin
      tone_edge = st_reg.ts[1] ^ st_reg.ts[2];
    end
    success = 1'b0;
    abort = 1'b0;
    rem = tone_meter_pkg::WIN_TICKS - st_reg.edge_tick;
    // Measurement window.
    case (st_reg.mstate)
      tone_meter_pkg::MEAS_IDLE:
      begin
        if (tone_edge && tone_ok)
        begin
          st_next.mstate = tone_meter_pkg::MEAS_RUN;
          st_next.pre = 8'h00;
          st_next.tcnt = 9'h000;
          st_next.ncnt = 8'h00;
          st_next.edge_tick = 9'h000;
        end
      end
      tone_meter_pkg::MEAS_RUN:
      begin
        if (!tone_ok)
        begin
          abort = 1'b1;
          st_next.mstate = tone_meter_pkg::MEAS_IDLE;
        end
        else
        begin
          if (tone_edge && st_reg.ncnt != 8'hFF)
          begin
            st_next.ncnt = st_reg.ncnt + 8'h01;
            st_next.edge_tick = round_tick(st_reg.tcnt, st_reg.pre, divisor);
          end
          if (tick)
          begin
            st_next.tcnt = st_reg.tcnt + 9'h001;
            if (st_reg.tcnt == tone_meter_pkg::WIN_TICKS - 9'h001)
            begin
              st_next.mstate = tone_meter_pkg::MEAS_IDLE;
              success = (st_reg.ncnt != 8'h00);
            end
          end
        end
      end
      default:
      begin
        st_next.mstate = tone_meter_pkg::MEAS_IDLE;
      end
    endcase
    // The remainder is what is left of the window after the last edge.
    if (success)
    begin
      st_next.res_n = st_reg.ncnt;
      st_next.res_r = (rem > 9'h0FF) ? 8'hFF : rem[7:0];
    end
    // ========================================================================
    // Serial slave: bits taken on bus clock rise, reply changes on fall.
    byte_done = 1'b0;
    wr_setting = 1'b0;
    gen_reset = 1'b0;
    stat_read = 1'b0;
    rx_byte = {st_reg.shreg[6:0], st_reg.bd[1]};
    if (st_reg.bs[1])
    begin
      st_next.bstate = tone_meter_pkg::BUS_ADDR;
      st_next.bitcnt = 3'h0;
      st_next.reply = 1'b0;
    end
    else if (st_reg.bc[1] && !st_reg.bc[2])
    begin
      st_next.shreg = rx_byte;
      st_next.bitcnt = st_reg.bitcnt + 3'h1;
      byte_done = (st_reg.bitcnt == 3'h7);
    end
    else if (!st_reg.bc[1] && st_reg.bc[2] && st_reg.bstate == tone_meter_pkg::BUS_RDATA)
    begin
      st_next.reply = st_reg.txreg[15];
      st_next.txreg = {st_reg.txreg[14:0], 1'b0};
    end
    if (byte_done)
    begin
      case (st_reg.bstate)
        tone_meter_pkg::BUS_ADDR:
        begin
          st_next.bstate = tone_meter_pkg::BUS_SKIP;
          if (rx_byte == tone_meter_pkg::CMD_NT_WRITE)
          begin
            st_next.bstate = tone_meter_pkg::BUS_WDATA;
          end
          else if (rx_byte == tone_meter_pkg::CMD_FREQ_READ)
          begin
            st_next.bstate = tone_meter_pkg::BUS_RDATA;
            st_next.txreg = {st_reg.res_n, st_reg.res_r};
          end
          else if (rx_byte == tone_meter_pkg::CMD_STAT_READ)
          begin
            stat_read = 1'b1;
            st_next.bstate = tone_meter_pkg::BUS_RDATA;
            st_next.txreg = 16'h0000;
            st_next.txreg[8 + tone_meter_pkg::STAT_MEAS_BIT] = st_reg.meas_flag;
            st_next.txreg[8 + tone_meter_pkg::STAT_NT_BIT] = st_reg.nt_flag;
          end
          else if (rx_byte == tone_meter_pkg::CMD_GEN_RESET)
          begin
            gen_reset = 1'b1;
          end
        end
        tone_meter_pkg::BUS_WDATA:
        begin
          // Accepted in any band or mode; the top nibble is ignored.
          wr_setting = 1'b1;
          st_next.setting = rx_byte[3:0];
          st_next.bstate = tone_meter_pkg::BUS_SKIP;
        end
        tone_meter_pkg::BUS_RDATA:
        begin
          // Reply bytes keep shifting out until the host deselects.
          st_next.bstate = tone_meter_pkg::BUS_RDATA;
        end
        default:
        begin
          st_next.bstate = tone_meter_pkg::BUS_SKIP;
        end
      endcase
    end
    if (gen_reset)
    begin
      st_next.setting = 4'h0;
      st_next.armed = 1'b0;
      st_next.pending = 1'b0;
    end
    // ========================================================================
    // No-tone timer: holds while a good measurement runs, counts otherwise.
    expire = 1'b0;
    late = (st_reg.mstate == tone_meter_pkg::MEAS_RUN) &&
           (st_reg.tcnt > tone_meter_pkg::LATE_TICKS);
    if (st_reg.armed && tick &&
        !(st_reg.mstate == tone_meter_pkg::MEAS_RUN && tone_ok))
    begin
      if (st_reg.nt_cnt == 15'h0001)
      begin
        expire = 1'b1;
        st_next.armed = 1'b0;
        st_next.pending = late;
      end
      else
      begin
        st_next.nt_cnt = st_reg.nt_cnt - 15'h0001;
      end
    end
    if (success)
    begin
      // Only a good window primes the countdown; nothing else arms it.
      st_next.armed = (st_reg.setting != 4'h0);
      st_next.pending = 1'b0;
      st_next.nt_cnt = 15'(st_reg.setting * NT_UNIT);
    end
    if (abort && st_reg.pending)
    begin
      st_next.pending = 1'b0;
    end
    // ========================================================================
    // Status flags: clears first, so a same-cycle set wins.
    if (stat_read || gen_reset)
    begin
      st_next.meas_flag = 1'b0;
      st_next.nt_flag = 1'b0;
    end
    if (wr_setting)
    begin
      st_next.nt_flag = 1'b0;
    end
    if (success)
    begin
      st_next.meas_flag = 1'b1;
    end
    if ((expire && !late) || (abort && st_reg.pending))
    begin
      st_next.nt_flag = 1'b1;
    end
    st_next.irq_n = ~((st_next.meas_flag & irq_en_meas) |
                      (st_next.nt_flag & irq_en_notone));
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.irq_n <= 1'b1;
      // The select synchroniser starts deselected, matching the idle pin.
      st_reg.bs <= 2'b11;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign bus_reply = st_reg.reply;
  assign irq_n = st_reg.irq_n;

  // ==========================================================================
  // Checks.
  a_meas_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    success |=> st_reg.meas_flag)
    else $error("Measurement flag not set after a good window.");

  a_result_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !success |=> $stable({st_reg.res_n, st_reg.res_r}))
    else $error("Result changed without a good window.");

  a_result_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    success |=> st_reg.res_n == $past(st_reg.ncnt))
    else $error("Integer byte does not match the cycle count.");

  a_window_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    success |-> tick && st_reg.tcnt == tone_meter_pkg::WIN_TICKS - 9'h001)
    else $error("Window did not last 511 ticks.");

  a_irq_meas: assert property (@(posedge core_clk) disable iff (!rst_n)
    (success && irq_en_meas) ##1 irq_en_meas |=> !irq_n)
    else $error("Interrupt not raised for a finished measurement.");

  a_nt_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(st_reg.nt_flag) |-> $past(st_reg.armed) || $past(st_reg.pending))
    else $error("No-tone flag raised without a primed countdown.");

  a_nt_expire: assert property (@(posedge core_clk) disable iff (!rst_n)
    (expire && !late) |=> st_reg.nt_flag && !st_reg.armed)
    else $error("Expiry did not set the no-tone flag.");

  a_late_defer: assert property (@(posedge core_clk) disable iff (!rst_n)
    (expire && late && !success) |=> st_reg.pending)
    else $error("Late expiry was not deferred.");

  a_nt_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
    (success && st_reg.setting != 4'h0) |=>
      st_reg.armed && st_reg.nt_cnt == 15'($past(st_reg.setting) * NT_UNIT))
    else $error("Countdown not reloaded after a good window.");

  a_setting_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_setting |=> st_reg.setting == $past(rx_byte[3:0]))
    else $error("Timer setting not taken from the data byte.");

  a_gen_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    gen_reset |=> st_reg.setting == 4'h0 && !st_reg.armed)
    else $error("General reset did not clear the timer setting.");

endmodule

// ---- testbench/host_model.sv ----
// Host controller model that speaks the serial command bus of the meter.
// Assumes a free running core_clk; bus levels are timed in its cycles.
`timescale 1ns/100ps
module host_model (
  input  wire logic       core_clk,
  input  wire logic       bus_reply,
  output logic            bus_clk,
  output logic            bus_cmd,
  output logic            bus_csn,
  output logic            rd_valid,
  output logic [7:0]      rd_byte
);
  integer seed;

  // ==========================================================================
  // Idle: clock parked low, select high, data line left wandering.
  initial
  begin
    seed = 32'h53163A1A;
    bus_clk = 1'b0;
    bus_cmd = 1'b0;
    bus_csn = 1'b1;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
  end

  // ==========================================================================
  // One byte each way; six core cycles per level keeps well above the minimum.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      bus_cmd <= tx[i];
      repeat (6) @(posedge core_clk);
      rx[i] = bus_reply;
      bus_clk <= 1'b1;
      repeat (6) @(posedge core_clk);
      bus_clk <= 1'b0;
    end
  endtask

  // ==========================================================================
  // A whole frame: command, optional data byte, then reply bytes.
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wdata,
                       input int nw, input int nr);
    logic [7:0] b;
    @(posedge core_clk);
    bus_csn <= 1'b0;
    xfer(cmd, b);
    if (nw > 0)
      xfer({4'h0, wdata[3:0]}, b);
    for (int k = 0; k < nr; k++)
    begin
      xfer(8'($random(seed)), b);
      rd_byte <= b;
      rd_valid <= 1'b1;
      @(posedge core_clk);
      rd_valid <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
    bus_csn <= 1'b1;
    // A released line must not keep its last level, or a stale bit could pass.
    bus_cmd <= ~bus_cmd;
    // Keep the select high long enough for the slave's synchroniser to see it.
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// ---- testbench/tb_rx_tone_meter.sv ----
// Self-checking bench for the tone meter and its no-tone timer.
// Assumes the host model on the serial bus and a fast crystal square wave.
`timescale 1ns/100ps
module tb_rx_tone_meter;
  logic       core_clk, rst_n, xtal_pin, tone_pin, tone_ok, tone_run;
  logic       irq_en_meas, irq_en_notone, bus_clk, bus_cmd, bus_csn;
  logic       bus_reply, irq_n, rd_valid;
  logic [1:0] band_sel;
  logic [7:0] rd_byte;
  logic [7:0] exp_q[$];
  int         failures, checks_done, cyc, t0;
  logic       nt_in_time;
  // A short no-tone step keeps the whole run inside the cycle budget.
  localparam int NT_TB  = 25;
  localparam int NT_CYC = NT_TB * 2 * int'(tone_meter_pkg::XTAL_PER_TICK_HI);

  rx_tone_meter #(
    .NT_UNIT(15'(NT_TB))
  ) rx_tone_meter_inst (
    .core_clk(core_clk), .rst_n(rst_n), .xtal_pin(xtal_pin),
    .tone_pin(tone_pin), .tone_ok(tone_ok), .band_sel(band_sel),
    .irq_en_meas(irq_en_meas), .irq_en_notone(irq_en_notone),
    .bus_clk(bus_clk), .bus_cmd(bus_cmd), .bus_csn(bus_csn),
    .bus_reply(bus_reply), .irq_n(irq_n));

  host_model host_model_inst (
    .core_clk(core_clk), .bus_reply(bus_reply), .bus_clk(bus_clk),
    .bus_cmd(bus_cmd), .bus_csn(bus_csn), .rd_valid(rd_valid), .rd_byte(rd_byte));

  // ==========================================================================
  // Clocks: 50 MHz core, crystal toggling every cycle to keep windows short.
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) xtal_pin <= ~xtal_pin;

  // Tone source: half period of 400 core cycles, frozen when not running.
  always
  begin
    repeat (400) @(posedge core_clk);
    if (tone_run)
      tone_pin <= ~tone_pin;
  end

  // ==========================================================================
  // Comparison, verdict and hang guard.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      failures++;
      summarize();
    end
  end

  // Watcher: every reply byte is matched against the oldest note.
  always @(posedge core_clk)
    if (rd_valid === 1'b1)
      check("reply", rd_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);

  // Bounded wait for the interrupt line to go low.
  task automatic wait_irq(input int limit);
    for (int i = 0; i < limit && irq_n !== 1'b0; i++)
      @(posedge core_clk);
  endtask

  task automatic stat_read(input logic [7:0] exp);
    exp_q.push_back(exp);
    host_model_inst.frame(tone_meter_pkg::CMD_STAT_READ, 8'h00, 0, 1);
  endtask

  // ==========================================================================
  // Main sequence: prime, measure one high band tone, then let it fade away.
  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    xtal_pin = 1'b0;
    tone_pin = 1'b0;
    tone_run = 1'b0;
    tone_ok = 1'b1;
    band_sel = tone_meter_pkg::BAND_HIGH;
    irq_en_meas = 1'b1;
    irq_en_notone = 1'b1;
    failures = 0;
    checks_done = 0;
    cyc = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("irq after reset", {7'h00, irq_n}, 8'h01);
    stat_read(8'h00);
    host_model_inst.frame(tone_meter_pkg::CMD_NT_WRITE, 8'h01, 1, 0);
    tone_run <= 1'b1;
    wait_irq(76000);
    t0 = cyc;
    tone_run <= 1'b0;
    check("irq on result", {7'h00, irq_n}, 8'h00);
    stat_read(8'h01);
    check("irq after read", {7'h00, irq_n}, 8'h01);
    // 400-cycle half periods over 511 ticks of 144 cycles: 183 edges, 3 left.
    exp_q.push_back(8'hB7);
    exp_q.push_back(8'h03);
    host_model_inst.frame(tone_meter_pkg::CMD_FREQ_READ, 8'h00, 0, 2);
    wait_irq(NT_CYC);
    // One code step is NT_TB ticks of 144 cycles here, held to one percent.
    nt_in_time = (cyc - t0 > NT_CYC - NT_CYC / 100) && (cyc - t0 < NT_CYC + NT_CYC / 100);
    check("notone time", {7'h00, nt_in_time}, 8'h01);
    stat_read(8'h02);
    host_model_inst.frame(tone_meter_pkg::CMD_GEN_RESET, 8'h00, 0, 0);
    stat_read(8'h00);
    wait_irq(3000);
    check("one shot", {7'h00, irq_n}, 8'h01);
    // A window cut short by a lost tone must leave the old result in place.
    tone_run <= 1'b1;
    repeat (1000) @(posedge core_clk);
    tone_ok <= 1'b0;
    tone_run <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("irq after abort", {7'h00, irq_n}, 8'h01);
    exp_q.push_back(8'hB7);
    exp_q.push_back(8'h03);
    host_model_inst.frame(tone_meter_pkg::CMD_FREQ_READ, 8'h00, 0, 2);
    repeat (20) @(posedge core_clk);
    summarize();
  end
endmodule
